// file: hdl/drive_param_pkg.sv
// constants of the drive parameter bank: object indices, defaults, codes
// assumes a 125 MHz device clock and a 16-bit object access port
package drive_param_pkg;
   // object indices
   localparam logic [15:0] IDX_OP_CUR = 16'h202a;
   localparam logic [15:0] IDX_HOLD = 16'h202b;
   localparam logic [15:0] IDX_ROT = 16'h202c;
   localparam logic [15:0] IDX_APPR = 16'h202d;
   localparam logic [15:0] IDX_PAUSE = 16'h202e;
   localparam logic [15:0] IDX_BLOCK = 16'h202f;
   localparam logic [15:0] IDX_SPEED = 16'h2030;
   localparam logic [15:0] IDX_LAG = 16'h2032;
   localparam logic [15:0] IDX_MOTION = 16'h2034;
   localparam logic [15:0] IDX_BUS = 16'h2035;
   localparam logic [15:0] IDX_BOOT = 16'h2037;
   localparam logic [15:0] IDX_SEC = 16'h2038;
   localparam logic [15:0] IDX_MFG = 16'h2040;
   localparam logic [15:0] IDX_SERIAL = 16'h2041;
   localparam logic [15:0] IDX_SAVE = 16'h204f;
   localparam logic [15:0] IDX_ENC = 16'h2501;
   // defaults
   localparam logic RST_OP_CUR = 1'b0;
   localparam logic [1:0] RST_HOLD = 2'h2;
   localparam logic RST_ROT = 1'b0;
   localparam logic RST_APPR = 1'b0;
   localparam logic [15:0] RST_PAUSE = 16'h000a;
   localparam logic RST_BLOCK = 1'b1;
   localparam logic [15:0] RST_LAG = 16'h0000;
   localparam logic [1:0] RST_BOOT = 2'h0;
   localparam logic RST_SEC = 1'b1;
   localparam logic [15:0] RST_ENC = 16'h3e80;
   // limits and codes
   localparam logic [1:0] HOLD_MAX = 2'h2;
   localparam logic [15:0] PAUSE_MAX = 16'h2710;
   localparam logic [7:0] BUS_OPER = 8'h05;
   localparam logic [7:0] BUS_PREOP = 8'h7f;
   localparam logic [7:0] CMD_SAVE = 8'h01;
   localparam logic [7:0] CMD_RESTORE = 8'hff;
   localparam logic [7:0] CMD_RESTORE_SAVE = 8'hfe;
   localparam logic [7:0] SAVE_OK = 8'h00;
   localparam logic [7:0] SAVE_FAIL = 8'hff;
   // retained image layout
   localparam int IMG_W = 25;
   localparam int IMG_OP = 0;
   localparam int IMG_HOLD = 1;
   localparam int IMG_ROT = 3;
   localparam int IMG_APPR = 4;
   localparam int IMG_PAUSE = 5;
   localparam int IMG_BLOCK = 21;
   localparam int IMG_BOOT = 22;
   localparam int IMG_SEC = 24;
   // reversal pause timing
   localparam int PAUSE_UNIT_NS = 1000000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CYC_PER_MS = PAUSE_UNIT_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      ST_BOOT = 2'b00,
      ST_IDLE = 2'b01,
      ST_SAVE = 2'b10
   } bank_state_t;
endpackage

// file: hdl/drive_param_bank.sv
// parameter and status object bank of a stepper positioning drive
// assumes object requests, nonvolatile store and motion signals all come
// from logic on clk_i, so no input is synchronised here
//
// Notes on behaviour
// - operating current: 0 high, 1 low; default 0; retained
// - holding current: 0 none, 1 low, 2 high; default 2
// - rotation sense: 0 counter-clockwise, 1 clockwise; default 0
// - approach: 0 half-turn forward loop, 1 half-turn reverse loop
// - pause programmed milliseconds on each reversal; 0..10000, default 10
// - obstacle: 0 abort only, 1 abort and back off 1.5 turns (default)
// - read-only speed code 0..7, 0 means stopped
// - lag maximum tracks largest difference after run end; starts at 0
// - read-only motion state code 5, 10, 20, 30 or 40
// - bus state reads 5 operational, 127 preoperational
// - boot config bit0 picks operational, bit1 suppresses error replies
// - secondary bit0 enables history recording; default 1; retained
// - writing 1 stores retained set; reads 0 on success, -1 on failure
// - writing -1 restores defaults without storing
// - writing -2 restores defaults and stores them
// - read-only encoder count 0..32000, nominal 16000
// - read-only manufacture year and week as YYWW integer
// - changing rotation or approach clears reference-completed flag
// - factory restore also clears reference-completed flag
// - zero holding current at standstill drops power-stage flag
`timescale 1ns/100ps
module drive_param_bank #(
   parameter int CYC_MS = drive_param_pkg::CYC_PER_MS, // cycles per ms
   parameter logic [15:0] MFG_WEEK = 16'h0000, // arbitrary value
   parameter logic [15:0] SERIAL = 16'h0000 // arbitrary value
) (
   input wire logic clk_i, // 125 MHz clock
   input wire logic rst_i, // async reset, high
   input wire logic ce_i, // clock enable
   input wire logic obj_rd_i, // object read request
   input wire logic obj_wr_i, // object write request
   input wire logic [15:0] obj_index_i, // object index
   input wire logic [15:0] obj_wdata_i, // write value
   output logic obj_ack_o, // answer pulse
   output logic obj_err_o, // access error with answer
   output logic [15:0] obj_rdata_o, // read value
   input wire logic nv_load_valid_i, // stored image presented
   input wire logic nv_load_ok_i, // image holds saved data
   input wire logic [24:0] nv_image_i, // stored image
   output logic nv_save_o, // store request pulse
   output logic [24:0] nv_image_o, // image to store
   input wire logic nv_done_i, // store finished pulse
   input wire logic nv_fail_i, // store failed, with done
   input wire logic [2:0] speed_code_i, // present speed code
   input wire logic [7:0] motion_state_i, // motion state code
   input wire logic [15:0] encoder_i, // encoder count
   input wire logic run_start_i, // positioning run starts
   input wire logic run_end_i, // positioning run ended
   input wire logic lag_valid_i, // lag sample strobe
   input wire logic [15:0] lag_i, // target-actual difference
   input wire logic reversal_i, // motor reverses
   input wire logic obstacle_i, // obstacle met
   input wire logic moving_i, // drive rotating
   input wire logic power_ok_i, // motor supply present
   input wire logic nmt_start_i, // go operational
   input wire logic nmt_preop_i, // go preoperational
   output logic low_op_current_o, // low operating current
   output logic [1:0] hold_level_o, // holding current level
   output logic clockwise_o, // positive is clockwise
   output logic reverse_approach_o, // approach with reverse loop
   output logic abort_o, // abort run pulse
   output logic back_off_o, // back off 1.5 turns pulse
   output logic pause_o, // reversal pause active
   output logic ref_clear_o, // clear reference-done pulse
   output logic power_stage_o, // power stage active
   output logic history_on_o, // history recording on
   output logic operational_o, // bus operational
   output logic boot_done_o // bank ready for requests
);
   drive_param_pkg::bank_state_t state;
   logic [15:0] pause_ms, lag_max, encoder, ms_left, rdata;
   logic [7:0] motion, save_result, w8;
   logic [1:0] boot_cfg;
   logic [2:0] speed;
   logic [16:0] cyc;
   logic [24:0] image, def_image, src_image;
   logic block_mode, post_run, b8ok;
   logic req, known, legal, wr_ok, err_en, restore, start_save, save_wr;

   // request decode; boot phase answers nothing
   assign req = ce_i && (obj_rd_i || obj_wr_i) &&
                state != drive_param_pkg::ST_BOOT;
   assign w8 = obj_wdata_i[7:0];
   assign b8ok = obj_wdata_i[15:8] == 8'h00;
   assign err_en = !boot_cfg[1];
   assign wr_ok = req && obj_wr_i && legal;
   assign save_wr = wr_ok && obj_index_i == drive_param_pkg::IDX_SAVE;
   assign restore = save_wr && w8 != drive_param_pkg::CMD_SAVE;
   assign start_save = save_wr && w8 != drive_param_pkg::CMD_RESTORE;

   // retained set packed in one image
   assign image = {history_on_o, boot_cfg, block_mode, pause_ms,
                   reverse_approach_o, clockwise_o, hold_level_o,
                   low_op_current_o};
   assign def_image = {drive_param_pkg::RST_SEC, drive_param_pkg::RST_BOOT,
                       drive_param_pkg::RST_BLOCK, drive_param_pkg::RST_PAUSE,
                       drive_param_pkg::RST_APPR, drive_param_pkg::RST_ROT,
                       drive_param_pkg::RST_HOLD, drive_param_pkg::RST_OP_CUR};
   assign src_image = restore ? def_image : nv_image_i; // restore reuses load

   // per-object read value and write legality
   always_comb begin
      known = 1'b1;
      legal = 1'b0;
      rdata = 16'h0000;
      case (obj_index_i)
         drive_param_pkg::IDX_OP_CUR: begin
            rdata = {15'h0000, low_op_current_o};
            legal = b8ok && w8 <= 8'h01;
         end
         drive_param_pkg::IDX_HOLD: begin
            rdata = {14'h0000, hold_level_o};
            legal = b8ok && w8 <= {6'h00, drive_param_pkg::HOLD_MAX};
         end
         drive_param_pkg::IDX_ROT: begin
            rdata = {15'h0000, clockwise_o};
            legal = b8ok && w8 <= 8'h01;
         end
         drive_param_pkg::IDX_APPR: begin
            rdata = {15'h0000, reverse_approach_o};
            legal = b8ok && w8 <= 8'h01;
         end
         drive_param_pkg::IDX_PAUSE: begin
            rdata = pause_ms;
            legal = obj_wdata_i <= drive_param_pkg::PAUSE_MAX;
         end
         drive_param_pkg::IDX_BLOCK: begin
            rdata = {15'h0000, block_mode};
            legal = b8ok && w8 <= 8'h01;
         end
         drive_param_pkg::IDX_SPEED: rdata = {13'h0000, speed};
         drive_param_pkg::IDX_LAG: begin
            rdata = lag_max;
            legal = 1'b1;
         end
         drive_param_pkg::IDX_MOTION: rdata = {8'h00, motion};
         drive_param_pkg::IDX_BUS: rdata = {8'h00, operational_o ?
            drive_param_pkg::BUS_OPER : drive_param_pkg::BUS_PREOP};
         drive_param_pkg::IDX_BOOT: begin
            rdata = {14'h0000, boot_cfg};
            legal = b8ok && w8 <= 8'h03;
         end
         drive_param_pkg::IDX_SEC: begin
            rdata = {15'h0000, history_on_o};
            legal = b8ok && w8 <= 8'h01;
         end
         drive_param_pkg::IDX_MFG: rdata = MFG_WEEK;
         drive_param_pkg::IDX_SERIAL: rdata = SERIAL;
         drive_param_pkg::IDX_SAVE: begin
            rdata = {8'h00, save_result};
            legal = b8ok && state == drive_param_pkg::ST_IDLE &&
                    (w8 == drive_param_pkg::CMD_SAVE ||
                     w8 == drive_param_pkg::CMD_RESTORE ||
                     w8 == drive_param_pkg::CMD_RESTORE_SAVE);
         end
         drive_param_pkg::IDX_ENC: rdata = encoder;
         default: known = 1'b0;
      endcase
   end

   // answer: one cycle after the request
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         obj_ack_o <= 1'b0;
         obj_err_o <= 1'b0;
         obj_rdata_o <= 16'h0000;
      end else if (ce_i) begin
         obj_ack_o <= req;
         obj_err_o <= req && err_en &&
                      (!known || (obj_wr_i && !legal));
         obj_rdata_o <= (req && !obj_wr_i) ? rdata : 16'h0000;
      end
   end

   // boot load and store sequencing
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= drive_param_pkg::ST_BOOT;
         nv_save_o <= 1'b0;
         nv_image_o <= 25'h0000000;
         save_result <= drive_param_pkg::SAVE_OK;
         boot_done_o <= 1'b0;
      end else if (ce_i) begin
         nv_save_o <= 1'b0;
         case (state)
            drive_param_pkg::ST_BOOT: begin
               if (nv_load_valid_i) begin
                  state <= drive_param_pkg::ST_IDLE;
                  boot_done_o <= 1'b1;
               end
            end
            drive_param_pkg::ST_IDLE: begin
               if (start_save) begin
                  state <= drive_param_pkg::ST_SAVE;
                  nv_save_o <= 1'b1;
                  nv_image_o <= (w8 == drive_param_pkg::CMD_SAVE) ?
                                image : def_image;
               end
            end
            drive_param_pkg::ST_SAVE: begin
               if (nv_done_i) begin
                  state <= drive_param_pkg::ST_IDLE;
                  save_result <= nv_fail_i ? drive_param_pkg::SAVE_FAIL :
                                 drive_param_pkg::SAVE_OK;
               end
            end
            default: state <= drive_param_pkg::ST_BOOT;
         endcase
      end
   end

   // retained settings: load at boot, restore, or master write
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_op_current_o <= drive_param_pkg::RST_OP_CUR;
         hold_level_o <= drive_param_pkg::RST_HOLD;
         clockwise_o <= drive_param_pkg::RST_ROT;
         reverse_approach_o <= drive_param_pkg::RST_APPR;
         pause_ms <= drive_param_pkg::RST_PAUSE;
         block_mode <= drive_param_pkg::RST_BLOCK;
         boot_cfg <= drive_param_pkg::RST_BOOT;
         history_on_o <= drive_param_pkg::RST_SEC;
      end else if (ce_i) begin
         if ((state == drive_param_pkg::ST_BOOT && nv_load_valid_i &&
              nv_load_ok_i) || restore) begin
            low_op_current_o <= src_image[drive_param_pkg::IMG_OP];
            hold_level_o <= src_image[drive_param_pkg::IMG_HOLD +: 2];
            clockwise_o <= src_image[drive_param_pkg::IMG_ROT];
            reverse_approach_o <= src_image[drive_param_pkg::IMG_APPR];
            pause_ms <= src_image[drive_param_pkg::IMG_PAUSE +: 16];
            block_mode <= src_image[drive_param_pkg::IMG_BLOCK];
            boot_cfg <= src_image[drive_param_pkg::IMG_BOOT +: 2];
            history_on_o <= src_image[drive_param_pkg::IMG_SEC];
         end else if (wr_ok) begin
            case (obj_index_i)
               drive_param_pkg::IDX_OP_CUR: low_op_current_o <= w8[0];
               drive_param_pkg::IDX_HOLD: hold_level_o <= w8[1:0];
               drive_param_pkg::IDX_ROT: clockwise_o <= w8[0];
               drive_param_pkg::IDX_APPR: reverse_approach_o <= w8[0];
               drive_param_pkg::IDX_PAUSE: pause_ms <= obj_wdata_i;
               drive_param_pkg::IDX_BLOCK: block_mode <= w8[0];
               drive_param_pkg::IDX_BOOT: boot_cfg <= w8[1:0];
               drive_param_pkg::IDX_SEC: history_on_o <= w8[0];
               default: ;
            endcase
         end
      end
   end

   // bus state: boot config picks the start, network commands move it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         operational_o <= 1'b0;
      end else if (ce_i) begin
         if (state == drive_param_pkg::ST_BOOT && nv_load_valid_i) begin
            operational_o <= nv_load_ok_i ?
               nv_image_i[drive_param_pkg::IMG_BOOT] :
               drive_param_pkg::RST_BOOT[0];
         end else if (nmt_start_i || nmt_preop_i) begin
            operational_o <= nmt_start_i; // start wins over preop
         end
      end
   end

   // read-only state sampled from the motion logic
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         speed <= 3'h0;
         motion <= 8'h00;
         encoder <= drive_param_pkg::RST_ENC;
      end else if (ce_i) begin
         speed <= speed_code_i;
         motion <= motion_state_i;
         encoder <= encoder_i;
      end
   end

   // lag maximum; run end setting the window beats run start clearing it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         post_run <= 1'b0;
         lag_max <= drive_param_pkg::RST_LAG;
      end else if (ce_i) begin
         post_run <= run_end_i || (post_run && !run_start_i);
         if (wr_ok && obj_index_i == drive_param_pkg::IDX_LAG) begin
            lag_max <= obj_wdata_i;
         end else if (run_start_i && !run_end_i) begin
            lag_max <= drive_param_pkg::RST_LAG;
         end else if (post_run && lag_valid_i && lag_i > lag_max) begin
            lag_max <= lag_i;
         end
      end
   end

   // reversal pause: pause_ms whole milliseconds, restarted by a new reversal
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pause_o <= 1'b0;
         ms_left <= 16'h0000;
         cyc <= 17'h00000;
      end else if (ce_i) begin
         if (reversal_i) begin
            pause_o <= pause_ms != 16'h0000;
            ms_left <= pause_ms;
            cyc <= 17'(CYC_MS - 1);
         end else if (pause_o) begin
            if (cyc != 17'h00000) begin
               cyc <= cyc - 17'h00001;
            end else if (ms_left == 16'h0001) begin
               pause_o <= 1'b0;
               ms_left <= 16'h0000;
            end else begin
               ms_left <= ms_left - 16'h0001;
               cyc <= 17'(CYC_MS - 1);
            end
         end
      end
   end

   // obstacle response, reference clear and power stage flags
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         abort_o <= 1'b0;
         back_off_o <= 1'b0;
         ref_clear_o <= 1'b0;
         power_stage_o <= 1'b0;
      end else if (ce_i) begin
         abort_o <= obstacle_i;
         back_off_o <= obstacle_i && block_mode;
         // a rewrite of the same direction keeps the reference
         ref_clear_o <= restore || (wr_ok &&
            ((obj_index_i == drive_param_pkg::IDX_ROT &&
              w8[0] != clockwise_o) ||
             (obj_index_i == drive_param_pkg::IDX_APPR &&
              w8[0] != reverse_approach_o)));
         power_stage_o <= moving_i ||
            (power_ok_i && hold_level_o != 2'h0);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_op_cur_write: assert property (wr_ok &&
      obj_index_i == drive_param_pkg::IDX_OP_CUR && !restore
      |=> low_op_current_o == $past(obj_wdata_i[0]))
      else $error("operating current not stored");
   chk_hold_range: assert property (hold_level_o != 2'h3)
      else $error("holding current out of range");
   chk_rot_refuse: assert property (req && obj_wr_i &&
      obj_index_i == drive_param_pkg::IDX_ROT && w8 > 8'h01
      |=> $stable(clockwise_o) && obj_err_o == $past(err_en))
      else $error("illegal rotation value accepted");
   chk_pause_start: assert property (ce_i && reversal_i &&
      pause_ms != 16'h0000 |=> pause_o ##1 (pause_o || !ce_i || reversal_i))
      else $error("reversal pause not started");
   chk_back_off: assert property (ce_i && obstacle_i
      |=> abort_o && back_off_o == $past(block_mode))
      else $error("obstacle response wrong");
   chk_lag_track: assert property (ce_i && post_run && lag_valid_i &&
      lag_i > lag_max && !run_start_i && !wr_ok
      |=> lag_max == $past(lag_i))
      else $error("lag maximum not captured");
   chk_ro_error: assert property (req && obj_wr_i && err_en &&
      obj_index_i == drive_param_pkg::IDX_SPEED |=> obj_ack_o && obj_err_o)
      else $error("read-only write not refused");
   chk_ref_clear: assert property (restore |=> ref_clear_o)
      else $error("restore kept reference flag");
   chk_power_off: assert property (ce_i && !moving_i &&
      hold_level_o == 2'h0 |=> !power_stage_o)
      else $error("power stage on without holding current");
   chk_boot_load: assert property (ce_i &&
      state == drive_param_pkg::ST_BOOT && nv_load_valid_i && nv_load_ok_i
      |=> hold_level_o == $past(nv_image_i[2:1]) && boot_done_o)
      else $error("retained set not loaded");
   chk_save_result: assert property (ce_i &&
      state == drive_param_pkg::ST_SAVE && nv_done_i
      |=> save_result == ($past(nv_fail_i) ? drive_param_pkg::SAVE_FAIL :
                          drive_param_pkg::SAVE_OK))
      else $error("save result wrong");

   cov_save: cover property (nv_save_o ##[1:20] nv_done_i);
   cov_restore: cover property (restore);
   cov_pause: cover property (pause_o ##1 !pause_o);
   cov_back_off: cover property (back_off_o);
endmodule

// file: bench/nv_store_model.sv
// nonvolatile store model facing the bank's store port
// assumes the bank and the store share one clock
`timescale 1ns/100ps
module nv_store_model (
   input wire logic clk_i, // device clock
   input wire logic rst_i, // async reset, high
   input wire logic save_i, // store request pulse
   input wire logic [24:0] image_i, // image to store
   input wire logic fail_i, // make stores fail
   output logic load_valid_o, // image presented
   output logic load_ok_o, // image holds saved data
   output logic [24:0] image_o, // stored image
   output logic done_o, // store finished pulse
   output logic fail_o // store failed, with done
);
   logic [1:0] busy;
   // slow store of three cycles, image offered as a level after reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         load_valid_o <= 1'b0;
         busy <= 2'h0;
      end else begin
         load_valid_o <= 1'b1;
         busy <= save_i ? 2'h3 : busy - {1'b0, busy != 2'h0};
      end
   end
   // result pulse when the countdown reaches one
   assign done_o = busy == 2'h1;
   assign fail_o = done_o & fail_i;
   // nothing saved after power-up, so the bank must fall back to defaults
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         load_ok_o <= 1'b0;
         image_o <= 25'h0;
      end else if (save_i) begin
         load_ok_o <= 1'b1;
         image_o <= image_i;
      end
   end
endmodule

// file: bench/positioning_drive_parameter_bank_tb_top.sv
// randomised test of the drive parameter bank beside a store model
// assumes the bank answers one cycle after taking a request
`timescale 1ns/100ps
module positioning_drive_parameter_bank_tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, nv_fail = 1'b0;
   logic run_end = 1'b0, lag_v = 1'b0, obst = 1'b0, moving = 1'b0, rvs = 1'b0;
   logic pwr = 1'b1, ack, err, lv, lok, sv, dn, fl, low_op, cw, rev_app;
   logic abort, back_off, pause, ref_clr, pstage, hist, oper, boot_done;
   logic [15:0] idx = 16'h0, wd = 16'h0, rdata, enc, lag = 16'h0, a, b;
   logic [24:0] limg, simg;
   logic [7:0] mstate;
   logic [2:0] speed;
   logic [1:0] hold_lvl;
   int n_errors = 0, n_checks = 0, k;
   logic [15:0] ti [9] = '{16'h202a, 16'h202b, 16'h202c, 16'h202d,
      16'h202e, 16'h202f, 16'h2032, 16'h2037, 16'h2038};
   logic [15:0] tv [9] = '{16'h0, 16'h2, 16'h0, 16'h0, 16'ha, 16'h1,
      16'h0, 16'h0, 16'h1};
   always #4 clk_i = !clk_i;
   nv_store_model u_nv (.clk_i(clk_i), .rst_i(rst_i), .save_i(sv),
      .image_i(simg), .fail_i(nv_fail), .load_valid_o(lv), .load_ok_o(lok),
      .image_o(limg), .done_o(dn), .fail_o(fl));
   drive_param_bank #(.CYC_MS(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .obj_rd_i(rd), .obj_wr_i(wr), .obj_index_i(idx),
      .obj_wdata_i(wd), .obj_ack_o(ack), .obj_err_o(err),
      .obj_rdata_o(rdata), .nv_load_valid_i(lv), .nv_load_ok_i(lok),
      .nv_image_i(limg), .nv_save_o(sv), .nv_image_o(simg),
      .nv_done_i(dn), .nv_fail_i(fl), .speed_code_i(speed),
      .motion_state_i(mstate), .encoder_i(enc), .run_start_i(1'b0),
      .run_end_i(run_end), .lag_valid_i(lag_v), .lag_i(lag),
      .reversal_i(rvs), .obstacle_i(obst), .moving_i(moving),
      .power_ok_i(pwr), .nmt_start_i(1'b0), .nmt_preop_i(1'b0),
      .low_op_current_o(low_op), .hold_level_o(hold_lvl), .clockwise_o(cw),
      .reverse_approach_o(rev_app), .abort_o(abort), .back_off_o(back_off),
      .pause_o(pause), .ref_clear_o(ref_clr), .power_stage_o(pstage),
      .history_on_o(hist), .operational_o(oper), .boot_done_o(boot_done));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // an edge passes before each access so strobes never toggle in one step
   task automatic acc(input logic w, input logic [15:0] i, d,
      input logic e, input logic [15:0] x);
      @(posedge clk_i) #1;
      wr = w;
      rd = !w;
      idx = i;
      wd = d;
      @(posedge clk_i) #1;
      wr = 1'b0;
      rd = 1'b0;
      cmp({14'h0, ack, err}, {14'h0, 1'b1, e});
      if (!w) cmp(rdata, x);
   endtask
   // store command, then the result once the store model has answered
   task automatic save(input logic [15:0] c, input logic f,
      input logic [15:0] x);
      nv_fail = f;
      acc(1'b1, 16'h204f, c, 1'b0, 16'h0);
      cmp({15'h0, sv}, 16'h1);
      for (k = 0; k < 10 && dn !== 1'b1; k++) @(posedge clk_i) #1;
      @(posedge clk_i) #1;
      acc(1'b0, 16'h204f, 16'h0, 1'b0, x);
   endtask
   task automatic hit(input logic [1:0] x);
      obst = 1'b1;
      @(posedge clk_i) #1;
      obst = 1'b0;
      cmp({14'h0, abort, back_off}, {14'h0, x});
   endtask
   function automatic logic [15:0] mx(input logic [15:0] p, q);
      return p > q ? p : q;
   endfunction
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // whole run is well under 2000 cycles
   initial begin
      #200000;
      n_errors++;
      test_done;
   end
   initial begin
      k = $urandom(67883);
      speed = 3'($urandom);
      mstate = 8'd20;
      enc = 16'($urandom_range(32000));
      a = 16'($urandom);
      b = 16'($urandom);
      repeat (2) @(posedge clk_i);
      #1 rst_i = 1'b0;
      for (k = 0; k < 20 && boot_done !== 1'b1; k++) @(posedge clk_i) #1;
      for (k = 0; k < 9; k++) acc(1'b0, ti[k], 16'h0, 1'b0, tv[k]);
      acc(1'b0, 16'h2035, 16'h0, 1'b0, 16'h7f);
      acc(1'b0, 16'h2030, 16'h0, 1'b0, {13'h0, speed});
      acc(1'b0, 16'h2034, 16'h0, 1'b0, 16'd20);
      acc(1'b0, 16'h2501, 16'h0, 1'b0, enc);
      acc(1'b0, 16'h2040, 16'h0, 1'b0, 16'h0);
      acc(1'b1, 16'h2030, 16'h1, 1'b1, 16'h0);
      acc(1'b1, 16'h202b, 16'h3, 1'b1, 16'h0);
      acc(1'b1, 16'h202c, 16'h2, 1'b1, 16'h0);
      acc(1'b1, 16'h202b, 16'h0, 1'b0, 16'h0);
      repeat (2) @(posedge clk_i) #1;
      cmp({13'h0, hold_lvl, pstage}, 16'h0);
      acc(1'b1, 16'h202e, 16'h2711, 1'b1, 16'h0);
      acc(1'b1, 16'h202e, a % 16'd10001, 1'b0, 16'h0);
      acc(1'b0, 16'h202e, 16'h0, 1'b0, a % 16'd10001);
      acc(1'b1, 16'h202c, 16'h1, 1'b0, 16'h0);
      cmp({15'h0, ref_clr}, 16'h1);
      acc(1'b1, 16'h202d, 16'h1, 1'b0, 16'h0);
      cmp({14'h0, cw, rev_app}, 16'h3);
      acc(1'b1, 16'h202a, 16'h1, 1'b0, 16'h0);
      acc(1'b1, 16'h2038, 16'h0, 1'b0, 16'h0);
      cmp({14'h0, low_op, hist}, 16'h2);
      hit(2'h3);
      acc(1'b1, 16'h202f, 16'h0, 1'b0, 16'h0);
      hit(2'h2);
      run_end = 1'b1;
      @(posedge clk_i) #1;
      {run_end, lag_v, lag} = {2'b01, a};
      @(posedge clk_i) #1;
      lag = b;
      @(posedge clk_i) #1;
      lag_v = 1'b0;
      acc(1'b0, 16'h2032, 16'h0, 1'b0, mx(a, b));
      save(16'h1, 1'b0, 16'h0);
      save(16'h1, 1'b1, 16'h00ff);
      acc(1'b1, 16'h204f, 16'h00ff, 1'b0, 16'h0);
      cmp({14'h0, ref_clr, sv}, 16'h2);
      acc(1'b0, 16'h202b, 16'h0, 1'b0, 16'h2);
      save(16'h00fe, 1'b0, 16'h0);
      // default pause of 10 ms at 4 cycles per ms: high for 40 cycles
      rvs = 1'b1;
      @(posedge clk_i) #1;
      rvs = 1'b0;
      cmp({15'h0, pause}, 16'h1);
      repeat (39) @(posedge clk_i) #1;
      cmp({15'h0, pause}, 16'h1);
      @(posedge clk_i) #1;
      cmp({15'h0, pause}, 16'h0);
      test_done;
   end
endmodule
